// ==== rtl/adcs_pkg.sv ====
// constants, register map and state type of the converter input select and sequencer
// assumes a single 125 MHz clock and an 8-bit register port
// Notes on behaviour
// - analog pin loses its digital functions
// - analog pin drops its pull-high resistor
// - analog pin overrides port direction control
// - source 000/101-111 routes pin channels 0-3
// - source 101-111, channel 4-15 leaves input floating
// - source 001 bandgap, 010 amp0, 011 amp1
// - bandgap enable bit, zero means high impedance
// - bandgap register upper seven bits read zero
// - 4 sample cycles then 12 convert cycles
// - conversion runs in hardware, no stall
// - start bit low-high-low starts conversion
// - busy high during conversion, result then valid
// - power enable low keeps converter off
// - 12-bit unsigned result, full scale fff
// - result format bit arranges high/low bytes
// - converter clock is system clock over 2^n
// - reference select 01 supply, else pin
// - completion sets flag, interrupt if enabled
package adcs_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] ADDR_CTRL_FIRST = 4'h0;
    localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
    localparam logic [3:0] ADDR_RESULT_HIGH = 4'h2;
    localparam logic [3:0] ADDR_RESULT_LOW = 4'h3;
    localparam logic [3:0] ADDR_BANDGAP_CTRL = 4'h4;
    localparam logic [3:0] ADDR_INT_CTRL = 4'h5;
    localparam logic [3:0] ADDR_PIN_FUNC = 4'h6;
    localparam logic [3:0] ADDR_PORT_CTRL = 4'h7;
    localparam logic [3:0] ADDR_PORT_DATA = 4'h8;
    localparam logic [3:0] ADDR_PORT_IN = 4'h9;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CF_START = 7;
    localparam int CF_BUSY = 6;
    localparam int CF_POWER = 5;
    localparam int CF_FORMAT = 4;
    localparam int CF_CHAN_LO = 0;
    localparam int CS_SRC_LO = 5;
    localparam int CS_REF_LO = 3;
    localparam int CS_DIV_LO = 0;
    localparam int BG_ENABLE = 0;
    localparam int IC_GLOBAL = 0;
    localparam int IC_CONV = 1;
    localparam int IC_FLAG = 2;
    localparam int PC_PULL_LO = 4;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [7:0] RST_CTRL_FIRST = 8'h00;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
    localparam logic [7:0] RST_BANDGAP = 8'h00;
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_PIN = 8'h00;
    localparam logic [2:0] SRC_EXT = 3'h0;
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_AMP0 = 3'h2;
    localparam logic [2:0] SRC_AMP1 = 3'h3;
    localparam logic [2:0] SRC_EXT_ALT_LO = 3'h5;
    localparam logic [1:0] REF_SUPPLY = 2'h1;

    // ****************************************
    // timing counts in converter clocks and result width
    // ****************************************
    localparam int SAMPLE_CYCLES = 4;
    localparam int CONVERT_CYCLES = 12;
    localparam int RESULT_BITS = 12;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } adcs_state_t;
endpackage

// ==== rtl/adcs_clk_div.sv ====
// converter clock enable divider
// assumes the sequencer holds run low between conversions
`timescale 1ns/1ps
module adcs_clk_div (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [2:0] divSel,
    output logic tick
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic tick_nxt;
    logic [6:0] mask;

    // ****************************************
    // divide by 2^divSel
    // ****************************************
    always_comb begin
        mask = 7'((8'h01 << divSel) - 8'h01);
        cnt_nxt = 7'h00;
        tick_nxt = 1'b0;
        if (run) begin
            cnt_nxt = 7'(cnt_r + 7'h01);
            tick_nxt = ((cnt_r & mask) == mask);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_r <= 7'h00;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule

// ==== rtl/adcs_top.sv ====
// converter input select, sequencer and shared pin control
// assumes an analog core that samples on sampleEn and compares against sarTrial
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module adcs_top #(
    parameter int NUM_PINS = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [NUM_PINS-1:0] padIn,
    output logic [NUM_PINS-1:0] padOut,
    output logic [NUM_PINS-1:0] padOe,
    output logic [NUM_PINS-1:0] pullHighEn,
    output logic [NUM_PINS-1:0] digInEn,
    input wire logic compIn,
    output logic [11:0] sarTrial,
    output logic sampleEn,
    output logic converterPowerEn,
    output logic [NUM_PINS-1:0] extChanConnect,
    output logic bandgapConnect,
    output logic amp0Connect,
    output logic amp1Connect,
    output logic refFromSupply,
    output logic bandgapOutEn,
    output logic busyOut,
    output logic irqOut
);
    if (NUM_PINS < 1 || NUM_PINS > 4) begin : g_bad_pins
        $error("NUM_PINS must be 1 to 4");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [NUM_PINS-1:0] padMeta_r;
    logic [NUM_PINS-1:0] padSync_r;
    logic compMeta_r;
    logic compSync_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            padMeta_r <= '0;
            padSync_r <= '0;
            compMeta_r <= 1'b0;
            compSync_r <= 1'b0;
        end else begin
            padMeta_r <= padIn;
            padSync_r <= padMeta_r;
            compMeta_r <= compIn;
            compSync_r <= compMeta_r;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    logic startBit_r, startBit_nxt;
    logic powerEn_r, powerEn_nxt;
    logic fmt_r, fmt_nxt;
    logic [3:0] chan_r, chan_nxt;
    logic [2:0] src_r, src_nxt;
    logic [1:0] refSel_r, refSel_nxt;
    logic [2:0] clkDiv_r, clkDiv_nxt;
    logic bgEn_r, bgEn_nxt;
    logic gie_r, gie_nxt;
    logic cie_r, cie_nxt;
    logic flag_r, flag_nxt;
    logic [3:0] anaEn_r, anaEn_nxt;
    logic [3:0] dir_r, dir_nxt;
    logic [3:0] pull_r, pull_nxt;
    logic [3:0] outData_r, outData_nxt;
    logic [7:0] rdata_nxt;
    logic [11:0] result_r;
    logic busy_r;
    logic doneEvt;
    logic [3:0] padSyncW;
    logic [7:0] resHigh;
    logic [7:0] resLow;

    always_comb begin
        padSyncW = 4'h0;
        padSyncW[NUM_PINS-1:0] = padSync_r & ~anaEn_r[NUM_PINS-1:0];
        if (fmt_r) begin
            resHigh = {4'h0, result_r[11:8]};
            resLow = result_r[7:0];
        end else begin
            resHigh = result_r[11:4];
            resLow = {result_r[3:0], 4'h0};
        end
    end

    always_comb begin
        startBit_nxt = startBit_r;
        powerEn_nxt = powerEn_r;
        fmt_nxt = fmt_r;
        chan_nxt = chan_r;
        src_nxt = src_r;
        refSel_nxt = refSel_r;
        clkDiv_nxt = clkDiv_r;
        bgEn_nxt = bgEn_r;
        gie_nxt = gie_r;
        cie_nxt = cie_r;
        flag_nxt = flag_r;
        anaEn_nxt = anaEn_r;
        dir_nxt = dir_r;
        pull_nxt = pull_r;
        outData_nxt = outData_r;
        rdata_nxt = 8'h00;
        if (regWr) begin
            case (regAddr)
                adcs_pkg::ADDR_CTRL_FIRST: begin
                    startBit_nxt = regWdata[adcs_pkg::CF_START];
                    powerEn_nxt = regWdata[adcs_pkg::CF_POWER];
                    fmt_nxt = regWdata[adcs_pkg::CF_FORMAT];
                    chan_nxt = regWdata[adcs_pkg::CF_CHAN_LO +: 4];
                end
                adcs_pkg::ADDR_CTRL_SECOND: begin
                    src_nxt = regWdata[adcs_pkg::CS_SRC_LO +: 3];
                    refSel_nxt = regWdata[adcs_pkg::CS_REF_LO +: 2];
                    clkDiv_nxt = regWdata[adcs_pkg::CS_DIV_LO +: 3];
                end
                adcs_pkg::ADDR_BANDGAP_CTRL: bgEn_nxt = regWdata[adcs_pkg::BG_ENABLE];
                adcs_pkg::ADDR_INT_CTRL: begin
                    gie_nxt = regWdata[adcs_pkg::IC_GLOBAL];
                    cie_nxt = regWdata[adcs_pkg::IC_CONV];
                    flag_nxt = regWdata[adcs_pkg::IC_FLAG];
                end
                adcs_pkg::ADDR_PIN_FUNC: anaEn_nxt = regWdata[3:0];
                adcs_pkg::ADDR_PORT_CTRL: begin
                    dir_nxt = regWdata[3:0];
                    pull_nxt = regWdata[adcs_pkg::PC_PULL_LO +: 4];
                end
                adcs_pkg::ADDR_PORT_DATA: outData_nxt = regWdata[3:0];
                default: ;
            endcase
        end
        if (doneEvt) begin
            flag_nxt = 1'b1;
        end
        if (regRd) begin
            case (regAddr)
                adcs_pkg::ADDR_CTRL_FIRST: begin
                    rdata_nxt = {startBit_r, busy_r, powerEn_r, fmt_r, chan_r};
                end
                adcs_pkg::ADDR_CTRL_SECOND: rdata_nxt = {src_r, refSel_r, clkDiv_r};
                adcs_pkg::ADDR_RESULT_HIGH: rdata_nxt = resHigh;
                adcs_pkg::ADDR_RESULT_LOW: rdata_nxt = resLow;
                adcs_pkg::ADDR_BANDGAP_CTRL: rdata_nxt = {7'h00, bgEn_r};
                adcs_pkg::ADDR_INT_CTRL: rdata_nxt = {5'h00, flag_r, cie_r, gie_r};
                adcs_pkg::ADDR_PIN_FUNC: rdata_nxt = {4'h0, anaEn_r};
                adcs_pkg::ADDR_PORT_CTRL: rdata_nxt = {pull_r, dir_r};
                adcs_pkg::ADDR_PORT_DATA: rdata_nxt = {4'h0, outData_r};
                adcs_pkg::ADDR_PORT_IN: rdata_nxt = {4'h0, padSyncW};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            {startBit_r, powerEn_r, fmt_r, chan_r} <= {adcs_pkg::RST_CTRL_FIRST[7],
                adcs_pkg::RST_CTRL_FIRST[5:0]};
            {src_r, refSel_r, clkDiv_r} <= adcs_pkg::RST_CTRL_SECOND;
            bgEn_r <= adcs_pkg::RST_BANDGAP[adcs_pkg::BG_ENABLE];
            {flag_r, cie_r, gie_r} <= adcs_pkg::RST_INT_CTRL[2:0];
            anaEn_r <= adcs_pkg::RST_PIN[3:0];
            {pull_r, dir_r} <= adcs_pkg::RST_PIN;
            outData_r <= adcs_pkg::RST_PIN[3:0];
            regRdata <= 8'h00;
        end else begin
            startBit_r <= startBit_nxt;
            powerEn_r <= powerEn_nxt;
            fmt_r <= fmt_nxt;
            chan_r <= chan_nxt;
            src_r <= src_nxt;
            refSel_r <= refSel_nxt;
            clkDiv_r <= clkDiv_nxt;
            bgEn_r <= bgEn_nxt;
            gie_r <= gie_nxt;
            cie_r <= cie_nxt;
            flag_r <= flag_nxt;
            anaEn_r <= anaEn_nxt;
            dir_r <= dir_nxt;
            pull_r <= pull_nxt;
            outData_r <= outData_nxt;
            regRdata <= rdata_nxt;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    adcs_pkg::adcs_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [11:0] sar_r, sar_nxt;
    logic [11:0] result_nxt;
    logic busy_nxt;
    logic startPrev_r;
    logic [2:0] latSrc_r, latSrc_nxt;
    logic [3:0] latChan_r, latChan_nxt;
    logic tick;
    logic [3:0] bitIdx;

    adcs_clk_div u_div (
        .mclk(mclk),
        .rstn(rstn),
        .run(busy_nxt),
        .divSel(clkDiv_r),
        .tick(tick)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sar_nxt = sar_r;
        result_nxt = result_r;
        busy_nxt = busy_r;
        latSrc_nxt = latSrc_r;
        latChan_nxt = latChan_r;
        doneEvt = 1'b0;
        bitIdx = 4'(adcs_pkg::RESULT_BITS - 1 - int'(cnt_r));
        case (state_r)
            adcs_pkg::ST_IDLE: begin
                if (startPrev_r && !startBit_r && powerEn_r) begin
                    state_nxt = adcs_pkg::ST_SAMPLE;
                    cnt_nxt = 4'h0;
                    busy_nxt = 1'b1;
                    latSrc_nxt = src_r;
                    latChan_nxt = chan_r;
                    sar_nxt = 12'h000;
                end
            end
            adcs_pkg::ST_SAMPLE: begin
                if (tick) begin
                    cnt_nxt = 4'(cnt_r + 4'h1);
                    if (cnt_r == 4'(adcs_pkg::SAMPLE_CYCLES - 1)) begin
                        state_nxt = adcs_pkg::ST_CONVERT;
                        cnt_nxt = 4'h0;
                        sar_nxt = 12'h800;
                    end
                end
            end
            adcs_pkg::ST_CONVERT: begin
                if (tick) begin
                    cnt_nxt = 4'(cnt_r + 4'h1);
                    sar_nxt[bitIdx] = compSync_r;
                    if (bitIdx != 4'h0) begin
                        sar_nxt[bitIdx - 4'h1] = 1'b1;
                    end
                    if (cnt_r == 4'(adcs_pkg::CONVERT_CYCLES - 1)) begin
                        state_nxt = adcs_pkg::ST_IDLE;
                        result_nxt = sar_nxt;
                        busy_nxt = 1'b0;
                        doneEvt = 1'b1;
                    end
                end
            end
            default: state_nxt = adcs_pkg::ST_IDLE;
        endcase
        if (startBit_r || !powerEn_r) begin
            state_nxt = adcs_pkg::ST_IDLE;
            busy_nxt = 1'b0;
            doneEvt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= adcs_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            sar_r <= 12'h000;
            result_r <= 12'h000;
            busy_r <= 1'b0;
            startPrev_r <= 1'b0;
            latSrc_r <= 3'h0;
            latChan_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sar_r <= sar_nxt;
            result_r <= result_nxt;
            busy_r <= busy_nxt;
            startPrev_r <= startBit_r;
            latSrc_r <= latSrc_nxt;
            latChan_r <= latChan_nxt;
        end
    end

    // ****************************************
    // analog routing and pin outputs
    // ****************************************
    logic [2:0] useSrc;
    logic [3:0] useChan;
    logic extSrc;
    logic [NUM_PINS-1:0] extConn_nxt;

    always_comb begin
        useSrc = busy_nxt ? latSrc_nxt : src_r;
        useChan = busy_nxt ? latChan_nxt : chan_r;
        extSrc = (useSrc == adcs_pkg::SRC_EXT) || (useSrc >= adcs_pkg::SRC_EXT_ALT_LO);
    end

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        assign extConn_nxt[i] = extSrc && (useChan == 4'(i));
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                padOut[i] <= 1'b0;
                padOe[i] <= 1'b0;
                pullHighEn[i] <= 1'b0;
                digInEn[i] <= 1'b1;
                extChanConnect[i] <= 1'b0;
            end else begin
                padOut[i] <= outData_r[i] && !anaEn_r[i];
                padOe[i] <= dir_r[i] && !anaEn_r[i];
                pullHighEn[i] <= pull_r[i] && !anaEn_r[i];
                digInEn[i] <= !anaEn_r[i];
                extChanConnect[i] <= extConn_nxt[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sarTrial <= 12'h000;
            sampleEn <= 1'b0;
            converterPowerEn <= 1'b0;
            bandgapConnect <= 1'b0;
            amp0Connect <= 1'b0;
            amp1Connect <= 1'b0;
            refFromSupply <= 1'b0;
            bandgapOutEn <= 1'b0;
            busyOut <= 1'b0;
            irqOut <= 1'b0;
        end else begin
            sarTrial <= sar_nxt;
            sampleEn <= (state_nxt == adcs_pkg::ST_SAMPLE);
            converterPowerEn <= powerEn_nxt;
            bandgapConnect <= (useSrc == adcs_pkg::SRC_BANDGAP);
            amp0Connect <= (useSrc == adcs_pkg::SRC_AMP0);
            amp1Connect <= (useSrc == adcs_pkg::SRC_AMP1);
            refFromSupply <= (refSel_nxt == adcs_pkg::REF_SUPPLY);
            bandgapOutEn <= bgEn_nxt;
            busyOut <= busy_nxt;
            irqOut <= flag_nxt && gie_nxt && cie_nxt;
        end
    end
endmodule

// ==== sim/adcs_props.sv ====
// concurrent checks on the ports of the converter select and sequencer
// assumes a bind onto adcs_top, one clock mclk and synchronous active-low rstn
`timescale 1ns/1ps
module adcs_props #(
    parameter int NUM_PINS = 4
) (
    input logic mclk,
    input logic rstn,
    input logic [3:0] regAddr,
    input logic [7:0] regWdata,
    input logic regWr,
    input logic regRd,
    input logic [7:0] regRdata,
    input logic [NUM_PINS-1:0] padOut,
    input logic [NUM_PINS-1:0] padOe,
    input logic [NUM_PINS-1:0] pullHighEn,
    input logic [NUM_PINS-1:0] digInEn,
    input logic [11:0] sarTrial,
    input logic sampleEn,
    input logic converterPowerEn,
    input logic [NUM_PINS-1:0] extChanConnect,
    input logic bandgapConnect,
    input logic amp0Connect,
    input logic amp1Connect,
    input logic bandgapOutEn,
    input logic busyOut,
    input logic irqOut
);
    // ****************************************
    // shadow of software settings
    // ****************************************
    logic [NUM_PINS-1:0] pinFunc_r;
    logic [NUM_PINS-1:0] pinFunc_nxt;
    logic bg_r;
    logic bg_nxt;
    logic [1:0] ie_r;
    logic [1:0] ie_nxt;
    always_comb begin
        pinFunc_nxt = pinFunc_r;
        bg_nxt = bg_r;
        ie_nxt = ie_r;
        if (regWr && regAddr == adcs_pkg::ADDR_PIN_FUNC) pinFunc_nxt = regWdata[NUM_PINS-1:0];
        if (regWr && regAddr == adcs_pkg::ADDR_BANDGAP_CTRL) bg_nxt = regWdata[0];
        if (regWr && regAddr == adcs_pkg::ADDR_INT_CTRL) ie_nxt = regWdata[1:0];
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pinFunc_r <= '0;
            bg_r <= 1'b0;
            ie_r <= 2'b00;
        end else begin
            pinFunc_r <= pinFunc_nxt;
            bg_r <= bg_nxt;
            ie_r <= ie_nxt;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    property p_pinDigOff;
        (pinFunc_r & $past(pinFunc_r) & (padOe | padOut | digInEn)) == '0;
    endproperty
    a_pinDigOff: assert property (p_pinDigOff) else $error("analog pin still digital");
    property p_pinPullOff;
        (pinFunc_r & $past(pinFunc_r) & pullHighEn) == '0;
    endproperty
    a_pinPullOff: assert property (p_pinPullOff) else $error("analog pin pulled high");
    property p_bgEn;
        $stable(bg_r) |-> bandgapOutEn == bg_r;
    endproperty
    a_bgEn: assert property (p_bgEn) else $error("bandgap enable wrong");
    property p_bgRead;
        regRd && regAddr == adcs_pkg::ADDR_BANDGAP_CTRL |=> regRdata[7:1] == 7'h00;
    endproperty
    a_bgRead: assert property (p_bgRead) else $error("bandgap upper bits not zero");
    property p_power;
        !converterPowerEn && !$past(converterPowerEn) |-> !busyOut && !sampleEn;
    endproperty
    a_power: assert property (p_power) else $error("converter active while off");
    property p_sampleLen;
        $rose(busyOut) |-> sampleEn [*4];
    endproperty
    a_sampleLen: assert property (p_sampleLen) else $error("sampling too short");
    property p_sampleInBusy;
        sampleEn |-> busyOut;
    endproperty
    a_sampleInBusy: assert property (p_sampleInBusy) else $error("sampling outside busy");
    property p_sarStart;
        $fell(sampleEn) && busyOut |-> ##[0:1] sarTrial == 12'h800;
    endproperty
    a_sarStart: assert property (p_sarStart) else $error("first trial not msb");
    property p_latch;
        busyOut && $past(busyOut) && $past(busyOut, 2) |-> $stable(extChanConnect)
            && $stable({bandgapConnect, amp0Connect, amp1Connect});
    endproperty
    a_latch: assert property (p_latch) else $error("source changed mid conversion");
    property p_decode;
        $onehot0({bandgapConnect, amp0Connect, amp1Connect}) && $onehot0(extChanConnect);
    endproperty
    a_decode: assert property (p_decode) else $error("several sources connected");
    property p_irqSet;
        $fell(busyOut) && ie_r == 2'b11 && $past(ie_r) == 2'b11 && !$past(regWr)
            && !$past(regWr, 2) && !$past(regWr, 3) |-> ##[0:2] irqOut;
    endproperty
    a_irqSet: assert property (p_irqSet) else $error("no interrupt on completion");
    property p_irqOff;
        ie_r != 2'b11 && $past(ie_r) != 2'b11 |-> !irqOut;
    endproperty
    a_irqOff: assert property (p_irqOff) else $error("interrupt while disabled");
endmodule

// ==== sim/adcs_bench.sv ====
// self-checking bench for the converter select and sequencer
// assumes adcs_top with four pins and the register map of adcs_pkg
`timescale 1ns/1ps
module adcs_bench;
    logic mclk;
    logic rstn;
    logic [3:0] regAddr;
    logic [7:0] regWdata;
    logic regWr, regRd;
    logic [7:0] regRdata;
    logic [3:0] padIn, padOut, padOe, pullHighEn, digInEn, extChanConnect;
    logic compIn, sampleEn, converterPowerEn, bandgapConnect, amp0Connect, amp1Connect;
    logic refFromSupply, bandgapOutEn, busyOut, irqOut;
    logic [11:0] sarTrial;
    logic [11:0] analogCode;
    int badCount, checkCount, busyCyc, sampCyc;
    // ****************************************
    // design, clock and analog model
    // ****************************************
    assign compIn = (analogCode >= sarTrial);
    adcs_top #(.NUM_PINS(4)) DUT (
        .mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .padIn, .padOut, .padOe,
        .pullHighEn, .digInEn, .compIn, .sarTrial, .sampleEn, .converterPowerEn,
        .extChanConnect, .bandgapConnect, .amp0Connect, .amp1Connect, .refFromSupply,
        .bandgapOutEn, .busyOut, .irqOut
    );
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (busyOut === 1'b1) busyCyc <= busyCyc + 1;
        if (sampleEn === 1'b1) sampCyc <= sampCyc + 1;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrapUp();
        if (badCount == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk(name, {8'h00, regRdata}, {8'h00, e});
    endtask
    task automatic sReset();
        chk("digInEn", {12'h000, digInEn}, 16'h000f);
        for (int i = 0; i < 10; i++) begin
            rd((i == 9) ? 4'hf : 4'(i), 8'h00, "resetReg");
        end
    endtask
    task automatic sPins();
        wr(adcs_pkg::ADDR_PORT_CTRL, 8'hff);
        wr(adcs_pkg::ADDR_PORT_DATA, 8'h0f);
        idle(3);
        chk("pinsDigital", {padOe, pullHighEn, padOut, digInEn}, 16'hffff);
        wr(adcs_pkg::ADDR_PIN_FUNC, 8'h05);
        idle(3);
        chk("pinsAnalog", {padOe, pullHighEn, padOut, digInEn}, 16'haaaa);
        rd(adcs_pkg::ADDR_PORT_IN, 8'h0a, "portIn");
        wr(adcs_pkg::ADDR_PIN_FUNC, 8'h00);
        wr(adcs_pkg::ADDR_PORT_CTRL, 8'h00);
    endtask
    task automatic sBandgap();
        wr(adcs_pkg::ADDR_BANDGAP_CTRL, 8'hff);
        rd(adcs_pkg::ADDR_BANDGAP_CTRL, 8'h01, "bandgapReg");
        idle(2);
        chk("bandgapOn", 16'(bandgapOutEn), 16'h0001);
        wr(adcs_pkg::ADDR_BANDGAP_CTRL, 8'h00);
        idle(3);
        chk("bandgapOff", 16'(bandgapOutEn), 16'h0000);
    endtask
    task automatic sRoute();
        logic [3:0] ch;
        logic [3:0] ext;
        for (int s = 0; s < 8; s++) begin
            for (int j = 0; j < 2; j++) begin
                ch = (j == 1) ? 4'h5 : 4'h2;
                if (ch < 4 && s >= 1 && s <= 4) continue;
                ext = ((s == 0 || s >= 5) && ch < 4) ? (4'h1 << ch) : 4'h0;
                wr(adcs_pkg::ADDR_CTRL_FIRST, {4'h0, ch});
                wr(adcs_pkg::ADDR_CTRL_SECOND, {3'(s), 2'(s), 3'h0});
                idle(2);
                chk("routing", {8'h00, refFromSupply, amp1Connect, amp0Connect, bandgapConnect,
                    extChanConnect}, {8'h00, 2'(s) == 2'h1, s == 3, s == 2, s == 1, ext});
            end
        end
    endtask
    task automatic sConvert(input logic [2:0] div, input logic [11:0] code, input logic fmt);
        int b0;
        int s0;
        int k;
        logic [7:0] c0;
        c0 = {3'b001, fmt, 4'h0};
        analogCode = code;
        wr(adcs_pkg::ADDR_CTRL_SECOND, {5'h00, div});
        wr(adcs_pkg::ADDR_CTRL_FIRST, c0);
        wr(adcs_pkg::ADDR_INT_CTRL, 8'h03);
        idle(4);
        b0 = busyCyc;
        s0 = sampCyc;
        wr(adcs_pkg::ADDR_CTRL_FIRST, c0 | 8'h80);
        wr(adcs_pkg::ADDR_CTRL_FIRST, c0);
        rd(adcs_pkg::ADDR_CTRL_FIRST, c0 | 8'h40, "busyBit");
        wr(adcs_pkg::ADDR_CTRL_FIRST, c0 | 8'h03);
        k = 0;
        while (busyOut === 1'b1 && k < 5000) begin
            idle(1);
            k++;
        end
        if (k == 5000) begin
            badCount++;
            wrapUp();
        end
        idle(2);
        chk("busyCycles", 16'(busyCyc - b0), 16'(16 << div));
        chk("sampleCycles", 16'(sampCyc - s0), 16'(4 << div));
        rd(adcs_pkg::ADDR_RESULT_HIGH, fmt ? {4'h0, code[11:8]} : code[11:4], "resHigh");
        rd(adcs_pkg::ADDR_RESULT_LOW, fmt ? code[7:0] : {code[3:0], 4'h0}, "resLow");
        rd(adcs_pkg::ADDR_INT_CTRL, 8'h07, "flagSet");
        chk("irqSet", 16'(irqOut), 16'h0001);
        wr(adcs_pkg::ADDR_INT_CTRL, 8'h03);
        idle(2);
        chk("irqClear", 16'(irqOut), 16'h0000);
        wr(adcs_pkg::ADDR_INT_CTRL, 8'h00);
    endtask
    task automatic sAbort();
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'h00);
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'h80);
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'h00);
        idle(4);
        chk("noPowerStart", {14'h0000, converterPowerEn, busyOut}, 16'h0000);
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'h20);
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'ha0);
        idle(4);
        chk("startHeld", {14'h0000, converterPowerEn, busyOut}, 16'h0002);
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'h20);
        idle(4);
        chk("started", {14'h0000, converterPowerEn, busyOut}, 16'h0003);
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'ha0);
        idle(4);
        chk("aborted", {14'h0000, converterPowerEn, busyOut}, 16'h0002);
        rd(adcs_pkg::ADDR_INT_CTRL, 8'h00, "noFlag");
        wr(adcs_pkg::ADDR_CTRL_FIRST, 8'h00);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        padIn = 4'hf;
        analogCode = 12'h000;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        idle(1);
        sReset();
        sPins();
        sBandgap();
        sRoute();
        sConvert(3'h2, 12'hfff, 1'b0);
        sConvert(3'h3, 12'h5a3, 1'b1);
        sAbort();
        wrapUp();
    end
endmodule
bind adcs_top adcs_props #(.NUM_PINS(NUM_PINS)) uProps (
    .mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .padOut, .padOe,
    .pullHighEn, .digInEn, .sarTrial, .sampleEn, .converterPowerEn, .extChanConnect,
    .bandgapConnect, .amp0Connect, .amp1Connect, .bandgapOutEn, .busyOut, .irqOut
);
